// ### logic/ser_router.sv
// Signal export router: dividers, marker stretcher, pin mux and AHB-Lite registers
`timescale 1ns/1ps
`include "ser_defines.svh"

// Notes on behaviour
// - Seven backplane trigger lines are export destinations
// - Sample clock divided for trigger and front lines
// - Timebase always divided before trigger or front
// - Timebase divisor accepted from 2 to 4194304
// - Timebase divisor is two after reset
// - Sample clock export: straight through or divided
// - Timebase drives block and is export source
// - PLL reference exported only while configured
// - Start trigger routable, never to clock output
// - Marker event marks configured waveform sample
// - Marker routable in arbitrary mode, not clock
// - Legacy trigger index x drives line x
// - Exported marker stretched to at least 150 ns
module ser_router
	import ser_pkg::*;
#(
	parameter int DIV_W  = `SER_DIV_W,
	parameter int TRIG_N = `SER_TRIG_N
) (
	// Clock, reset, enable
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              ce,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Internal timing sources
	input  wire logic              sample_clk,
	input  wire logic              start_cond,
	input  wire logic              marker_in,
	input  wire logic              pll_ref_clk,
	// Backplane trigger lines
	output logic [TRIG_N-1:0]      trig_out,
	output logic [TRIG_N-1:0]      trig_oe,
	// Front panel lines
	output logic                   front_line_a_out,
	output logic                   front_line_a_oe,
	output logic                   front_line_b_out,
	output logic                   front_line_b_oe,
	// Clock output connector
	output logic                   clk_out,
	output logic                   clk_oe
);

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam int MK_CYC_I = (`SER_MARK_NS * `SER_CLK_MHZ + 999) / 1000;
	localparam int MK_W     = 8;
	localparam logic [MK_W-1:0] MK_CYC = MK_W'((MK_CYC_I < 1) ? 1 : MK_CYC_I);
	localparam int DEST_N   = `SER_DEST_N;
	localparam int FW       = `SER_ROUTE_FW;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [`SER_CTRL_W-1:0]  ctrl;
	logic [DIV_W-1:0]        div_val [2];
	logic [DEST_N*FW-1:0]    route;
	logic                    div_rejected;
	logic                    wr_pend;
	logic [7:0]              wr_addr;
	logic                    addr_ok;
	logic                    div_ok;
	logic [DIV_W-1:0]        wr_div;

	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel & htrans[1] & hready & ce;
	assign wr_div    = hwdata[DIV_W-1:0];
	assign div_ok    = (hwdata[31:DIV_W] == '0) && (wr_div >= `SER_DIV_MIN)
		&& (wr_div <= `SER_DIV_MAX);

	// ----------------------------------------
	// Address phase capture
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (ce) begin
			wr_pend <= addr_ok & hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl         <= `SER_CTRL_RST;
			div_val[0]   <= `SER_DIV_RST;
			div_val[1]   <= `SER_DIV_RST;
			route        <= `SER_ROUTE_RST;
			div_rejected <= 1'b0;
		end else if (ce && wr_pend) begin
			unique case (wr_addr)
				`SER_OFF_CTRL: ctrl <= hwdata[`SER_CTRL_W-1:0];
				`SER_OFF_SCLKDIV: begin
					if (div_ok) begin
						div_val[0] <= wr_div;
					end
					div_rejected <= !div_ok;
				end
				`SER_OFF_TBDIV: begin
					if (div_ok) begin
						div_val[1] <= wr_div;
					end
					div_rejected <= !div_ok;
				end
				`SER_OFF_ROUTE: route <= hwdata[DEST_N*FW-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Sample clock edge detect
	// ----------------------------------------
	logic sclk_prev;
	logic sclk_q;
	logic sclk_rise;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_prev <= 1'b0;
			sclk_q    <= 1'b0;
		end else if (ce) begin
			sclk_prev <= sample_clk;
			sclk_q    <= sample_clk;
		end
	end

	assign sclk_rise = sample_clk & ~sclk_prev;

	// ----------------------------------------
	// Dividers: 0 sample clock, 1 timebase
	// ----------------------------------------
	logic [1:0] div_out;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_div
			logic [DIV_W-1:0] cnt;
			logic [DIV_W-1:0] next_cnt;
			logic             tick;

			// Timebase divider ticks every hclk, sample divider on its rising edges
			assign tick     = (gi == 0) ? sclk_rise : 1'b1;
			assign next_cnt = (cnt >= div_val[gi] - DIV_W'(1)) ? '0 : cnt + 1'b1;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt         <= '0;
					div_out[gi] <= 1'b0;
				end else if (ce && tick) begin
					cnt         <= next_cnt;
					div_out[gi] <= next_cnt < (div_val[gi] >> 1);
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Start trigger and marker stretcher
	// ----------------------------------------
	logic            start_q;
	logic            mark_q;
	logic [MK_W-1:0] mark_cnt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= 1'b0;
		end else if (ce) begin
			start_q <= start_cond;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mark_cnt <= '0;
			mark_q   <= 1'b0;
		end else if (ce) begin
			if (marker_in) begin
				mark_cnt <= MK_CYC;
			end else if (mark_cnt != '0) begin
				mark_cnt <= mark_cnt - 1'b1;
			end
			mark_q <= marker_in | (mark_cnt > MK_W'(1));
		end
	end

	// ----------------------------------------
	// Destination mux
	// ----------------------------------------
	logic [DEST_N-1:0] pin_q;
	logic [DEST_N-1:0] oe_q;

	generate
		for (gi = 0; gi < DEST_N; gi++) begin : g_dest
			ser_src_t sel;
			logic     next_pin;
			logic     next_oe;
			localparam bit IS_CLK = (gi == `SER_DEST_CLK);

			assign sel = ser_src_t'(route[gi*FW +: FW]);

			always_comb begin
				next_pin = 1'b0;
				next_oe  = 1'b1;
				unique case (sel)
					SER_SRC_SCLK: begin
						if (IS_CLK && !ctrl[`SER_CTRL_SCLK_DIV]) begin
							next_pin = sclk_q;
						end else begin
							next_pin = div_out[0];
						end
					end
					SER_SRC_TB: next_pin = div_out[1];
					SER_SRC_PLL: begin
						next_pin = ctrl[`SER_CTRL_PLL] & pll_ref_clk;
						next_oe  = ctrl[`SER_CTRL_PLL];
					end
					SER_SRC_START: begin
						next_pin = !IS_CLK & start_q;
						next_oe  = !IS_CLK;
					end
					SER_SRC_MARKER: begin
						next_oe  = !IS_CLK & ctrl[`SER_CTRL_AWG];
						next_pin = next_oe & mark_q;
					end
					default: begin
						next_pin = 1'b0;
						next_oe  = 1'b0;
					end
				endcase
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_q[gi] <= 1'b0;
					oe_q[gi]  <= 1'b0;
				end else if (ce) begin
					pin_q[gi] <= next_pin;
					oe_q[gi]  <= next_oe;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Pin assignment
	// ----------------------------------------
	assign trig_out         = pin_q[TRIG_N-1:0];
	assign trig_oe          = oe_q[TRIG_N-1:0];
	assign front_line_a_out = pin_q[`SER_DEST_FA];
	assign front_line_a_oe  = oe_q[`SER_DEST_FA];
	assign front_line_b_out = pin_q[`SER_DEST_FB];
	assign front_line_b_oe  = oe_q[`SER_DEST_FB];
	assign clk_out          = pin_q[`SER_DEST_CLK];
	assign clk_oe           = oe_q[`SER_DEST_CLK];

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ce && addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				`SER_OFF_CTRL:    hrdata <= 32'(ctrl);
				`SER_OFF_SCLKDIV: hrdata <= 32'(div_val[0]);
				`SER_OFF_TBDIV:   hrdata <= 32'(div_val[1]);
				`SER_OFF_ROUTE:   hrdata <= 32'(route);
				`SER_OFF_STATUS:  hrdata <= 32'({oe_q, pin_q, div_rejected});
				default:          hrdata <= 32'h00000000;
			endcase
		end
	end

endmodule

// ### logic/ser_defines.svh
// Offsets, field positions, reset values and timing figures of the export router
`ifndef SER_DEFINES_SVH
`define SER_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SER_OFF_CTRL    8'h00
`define SER_OFF_SCLKDIV 8'h04
`define SER_OFF_TBDIV   8'h08
`define SER_OFF_ROUTE   8'h0C
`define SER_OFF_STATUS  8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SER_CTRL_SCLK_DIV 0
`define SER_CTRL_AWG      1
`define SER_CTRL_PLL      2
`define SER_CTRL_W        3
`define SER_CTRL_RST      3'h0

// ----------------------------------------
// Divider range and reset
// ----------------------------------------
`define SER_DIV_W   23
`define SER_DIV_MIN 23'h000002
`define SER_DIV_MAX 23'h400000
`define SER_DIV_RST 23'h000002

// ----------------------------------------
// Route fields and destinations
// ----------------------------------------
`define SER_ROUTE_FW  3
`define SER_DEST_N    10
`define SER_TRIG_N    7
`define SER_DEST_FA   7
`define SER_DEST_FB   8
`define SER_DEST_CLK  9
`define SER_ROUTE_RST 30'h00000000

// ----------------------------------------
// Marker stretch timing
// ----------------------------------------
`define SER_MARK_NS 150
`define SER_CLK_MHZ 200

`endif

// ### logic/ser_pkg.sv
// Types shared by the export router
package ser_pkg;

	// Export source selected per destination
	typedef enum logic [2:0] {
		SER_SRC_NONE,
		SER_SRC_SCLK,
		SER_SRC_TB,
		SER_SRC_PLL,
		SER_SRC_START,
		SER_SRC_MARKER
	} ser_src_t;

endpackage

// ### bench/ser_far_model.sv
// Far-side instruments that see the exported lines
`timescale 1ns/1ps
module ser_far_model (
	// Pins
	input wire logic       hclk,
	input wire logic [9:0] drv,
	input wire logic [9:0] oe,
	// Levels seen
	output logic     [9:0] line
);
	logic [9:0] last = 10'h000;
	always @(posedge hclk) last <= line;
	// Released line shows the inverse of its last level
	assign line = (drv & oe) | (~last & ~oe);
endmodule

// ### bench/ser_router_chk.sv
// Checker of the export router ports
`timescale 1ns/1ps
module ser_router_chk #(
	parameter int TRIG_N = 7
) (
	// Clock and bus
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              ce,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic              hreadyout,
	// Sources and lines
	input wire logic              sample_clk,
	input wire logic              start_cond,
	input wire logic              marker_in,
	input wire logic [TRIG_N-1:0] trig_out,
	input wire logic [TRIG_N-1:0] trig_oe,
	input wire logic              front_line_a_out,
	input wire logic              front_line_a_oe,
	input wire logic              front_line_b_out,
	input wire logic              front_line_b_oe,
	input wire logic              clk_out,
	input wire logic              clk_oe
);
	logic        wp;
	logic [7:0]  wa;
	logic [29:0] rt;
	logic [2:0]  ct;
	logic [1:0]  age;
	// Shadow of route and control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wp, wa, rt, ct, age} <= '0;
		end else if (ce) begin
			wp <= hsel && htrans[1] && hwrite && hready;
			wa <= haddr[7:0];
			if (wp && wa == 8'h0C) rt <= hwdata[29:0];
			if (wp && wa == 8'h00) ct <= hwdata[2:0];
			age <= (wp && (wa == 8'h0C || wa == 8'h00)) ? 2'h0 : age + {1'h0, age != 2'h3};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_hold; front_line_b_out [*8]; endsequence
	property p_rdy; hreadyout == ce; endproperty
	a_rdy: assert property (p_rdy) else $error("ready wrong");
	// Route and control reach the pins one edge after the write edge
	property p_off;
		rt[2:0] == 3'h0 && age > 2'h1 |-> !trig_oe[0];
	endproperty
	a_off: assert property (p_off) else $error("idle line driven");
	property p_start;
		rt[20:18] == 3'h4 && age > 2'h1 |-> trig_oe[6] && trig_out[6] == $past(start_cond, 2);
	endproperty
	a_start: assert property (p_start) else $error("start path");
	property p_clk;
		rt[29:27] > 3'h3 && rt[29:27] < 3'h6 && age > 2'h1 |-> !clk_oe;
	endproperty
	a_clk: assert property (p_clk) else $error("event on clock out");
	property p_pll;
		rt[23:21] == 3'h3 && !ct[2] && age > 2'h1 |-> !front_line_a_oe;
	endproperty
	a_pll: assert property (p_pll) else $error("pll ref unconfigured");
	property p_awg;
		rt[26:24] == 3'h5 && !ct[1] && age > 2'h1 |-> !front_line_b_oe;
	endproperty
	a_awg: assert property (p_awg) else $error("marker outside mode");
	property p_mark;
		rt[26:24] == 3'h5 && ct[1] && age > 2'h1 && marker_in |=> ##1 s_hold;
	endproperty
	a_mark: assert property (p_mark) else $error("marker short");
	property p_pass;
		rt[29:27] == 3'h1 && !ct[0] && age > 2'h1 |-> clk_oe && clk_out == $past(sample_clk, 2);
	endproperty
	a_pass: assert property (p_pass) else $error("pass-through");
	// Both compared samples must already come from the new route
	property p_tb;
		rt[23:21] == 3'h2 && age == 2'h3
			|-> front_line_a_oe && front_line_a_out != $past(front_line_a_out);
	endproperty
	a_tb: assert property (p_tb) else $error("timebase half");
endmodule
bind ser_router ser_router_chk #(.TRIG_N(TRIG_N)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.sample_clk(sample_clk), .start_cond(start_cond), .marker_in(marker_in),
	.trig_out(trig_out), .trig_oe(trig_oe), .front_line_a_out(front_line_a_out),
	.front_line_a_oe(front_line_a_oe), .front_line_b_out(front_line_b_out),
	.front_line_b_oe(front_line_b_oe), .clk_out(clk_out), .clk_oe(clk_oe)
);

// ### bench/tb.sv
// Testbench of the export router
`timescale 1ns/1ps
module tb;
	logic        hclk, hresetn, ce, hsel, hwrite, hrdy, sample_clk, start_cond, marker_in, pll;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [6:0]  trig_out, trig_oe;
	logic        fa, fao, fb, fbo, co, coe;
	logic [9:0]  line;
	int          err_total, tests_run, n, r;
	ser_router dut (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
		.hresp(), .hrdata(hrdata), .sample_clk(sample_clk), .start_cond(start_cond),
		.marker_in(marker_in), .pll_ref_clk(pll), .trig_out(trig_out), .trig_oe(trig_oe),
		.front_line_a_out(fa), .front_line_a_oe(fao), .front_line_b_out(fb),
		.front_line_b_oe(fbo), .clk_out(co), .clk_oe(coe)
	);
	ser_far_model far (.hclk(hclk), .drv({co, fb, fa, trig_out}), .oe({coe, fbo, fao, trig_oe}),
		.line(line));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hrdy !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hrdy !== 1'h1);
		rv = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		chk(rv, e);
	endtask
	task automatic cnt(input int b, input int c, input bit hi);
		logic p;
		r = 0;
		p = line[b];
		repeat (c) begin
			@(posedge hclk);
			if (line[b] === 1'h1 && (hi || p === 1'h0)) r++;
			p = line[b];
		end
	endtask
	task automatic pulse();
		@(posedge hclk);
		marker_in <= 1'h1;
		@(posedge hclk);
		marker_in <= 1'h0;
	endtask
	task automatic close_out();
		$display("errors=%0d checks=%0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		hclk = 1'h0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) sample_clk <= ~sample_clk;
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		close_out();
	end
	initial begin
		{hsel, hwrite, start_cond, marker_in, pll, sample_clk, htrans, haddr, hwdata} = '0;
		{err_total, tests_run} = '0;
		ce = 1'h1;
		hresetn = 1'h0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		rd(8'h08, 32'h2);
		rd(8'h10, 32'h0);
		xfer(1'h1, 8'h20, 32'hFFFFFFFF);
		rd(8'h20, 32'h0);
		ce <= 1'h0;
		@(posedge hclk);
		@(posedge hclk);
		chk(32'(hrdy), 32'h0);
		ce <= 1'h1;
		xfer(1'h1, 8'h08, 32'h1);
		rd(8'h08, 32'h2);
		chk(32'(rv[0]), 32'h0);
		xfer(1'h0, 8'h10, 32'h0);
		chk(32'(rv[0]), 32'h1);
		xfer(1'h1, 8'h08, 32'h400001);
		rd(8'h08, 32'h2);
		xfer(1'h1, 8'h08, 32'h400000);
		rd(8'h08, 32'h400000);
		xfer(1'h1, 8'h08, 32'h2);
		start_cond <= 1'h1;
		for (n = 0; n < 7; n++) begin
			xfer(1'h1, 8'h0C, 32'h4 << (3 * n));
			repeat (3) @(posedge hclk);
			chk({25'h0, trig_oe}, 32'h1 << n);
			chk(32'(line[n]), 32'h1);
		end
		xfer(1'h1, 8'h0C, 32'h3 << 21 | 32'h4 << 27);
		pll <= 1'h1;
		repeat (3) @(posedge hclk);
		chk({30'h0, coe, fao}, 32'h0);
		xfer(1'h1, 8'h00, 32'h4);
		repeat (3) @(posedge hclk);
		chk({30'h0, fao, line[7]}, 32'h3);
		xfer(1'h1, 8'h0C, 32'h5 << 24);
		xfer(1'h1, 8'h00, 32'h0);
		pulse();
		chk(32'(fbo), 32'h0);
		xfer(1'h1, 8'h00, 32'h2);
		repeat (3) @(posedge hclk);
		pulse();
		cnt(8, 60, 1'h1);
		chk(32'(r >= 30 && r <= 32), 32'h1);
		xfer(1'h1, 8'h0C, 32'h2 << 21);
		repeat (4) @(posedge hclk);
		cnt(7, 20, 1'h0);
		chk(32'(r), 32'd10);
		xfer(1'h1, 8'h04, 32'h8);
		xfer(1'h1, 8'h00, 32'h1);
		xfer(1'h1, 8'h0C, 32'h1 << 27 | 32'h1);
		repeat (40) @(posedge hclk);
		cnt(9, 160, 1'h0);
		chk(32'(r), 32'd10);
		cnt(0, 160, 1'h0);
		chk(32'(r), 32'd10);
		xfer(1'h1, 8'h00, 32'h0);
		repeat (3) @(posedge hclk);
		cnt(9, 20, 1'h0);
		chk(32'(r), 32'd10);
		close_out();
	end
endmodule
